//--- rscl_strap_latch.sv
// Strap latch top: capture, decode and peripheral select register.
`timescale 1ns/100ps
`default_nettype none
`include "rscl_regs.svh"
module rscl_strap_latch
    import rscl_pkg::*;
#(
    parameter logic [31:0] CHIP_ID = 32'h00005A5A // Arbitrary value.
)(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        endianStrap,
    input  wire logic [1:0]  bootModeStrap,
    input  wire logic [1:0]  extMemClockSelectStrap,
    input  wire logic        pciEepromAutoinitStrap,
    input  wire logic        pciSpeedStrap,
    input  wire logic        hostWidthStrap,
    input  wire logic        pciSelectStrap,
    input  wire logic        ethernetSelectStrap,
    input  wire logic        cfgReq,
    input  wire logic        cfgWe,
    input  wire logic [31:0] cfgAddr,
    input  wire logic [3:0]  cfgByteEn,
    input  wire logic [31:0] cfgWdata,
    output logic      [31:0] cfgRdata,
    output logic             cfgAck,
    output logic             endianMode,
    output logic      [1:0]  bootMode,
    output logic             bootViaHost,
    output logic             bootViaPci,
    output logic             bootFromExtMem,
    output logic             bootReserved,
    output logic      [1:0]  extMemClockSelect,
    output logic             extMemClockReserved,
    output logic             pciEnable,
    output logic             pciEepromLoad,
    output logic             pciSpeed33,
    output logic             hostPortEnable,
    output logic             hostPort32bit,
    output logic             hostDataUpperHiZ,
    output logic             ethernetEnable,
    output logic             selectReserved,
    output logic             configReady,
    output logic      [2:0]  videoPortEnable,
    output logic             i2cEnable,
    output logic             serialPort0Enable,
    output logic             serialPort1Enable,
    output logic             audioPortEnable
);
    rscl_cfg_if   ifc ();
    rscl_straps_t pinStraps;
    rscl_straps_t cap;
    rscl_phase_t  phase;
    rscl_phase_t  next_phase;
    logic         next_ready;
    logic         selPci;
    logic         selEth;
    logic         selRsvd;
    logic         hostOn;

    // Gather the pins into one word for the capture stage.
    assign pinStraps = {endianStrap, rscl_boot_t'(bootModeStrap),
                        rscl_mclk_t'(extMemClockSelectStrap),
                        pciEepromAutoinitStrap, pciSpeedStrap,
                        hostWidthStrap, pciSelectStrap,
                        ethernetSelectStrap};

    rscl_strap_capture u_capture (
        .clk  (clk),
        .rst  (rst),
        .pins (pinStraps),
        .cfg  (ifc.cap)
    );

    // Bus requests go straight through; only this port reaches them.
    assign ifc.req    = cfgReq;
    assign ifc.we     = cfgWe;
    assign ifc.addr   = cfgAddr;
    assign ifc.byteEn = cfgByteEn;
    assign ifc.wdata  = cfgWdata;
    assign cfgRdata   = ifc.rdata;
    assign cfgAck     = ifc.ack;

    rscl_cfg_regs #(
        .CHIP_ID (CHIP_ID)
    ) u_regs (
        .clk (clk),
        .rst (rst),
        .cfg (ifc.regs)
    );

    // Peripheral selection from the frozen select straps.
    assign cap     = ifc.straps;
    assign selPci  = cap.pciSel && !cap.macSel;
    assign selEth  = !cap.pciSel && cap.macSel;
    assign selRsvd = cap.pciSel && cap.macSel;
    // Ethernet takes the upper data lines, so a wide port cannot coexist.
    assign hostOn  = !cap.pciSel && !(cap.macSel && cap.width);

    // Phase tracks release of reset; ready comes one cycle after decode.
    always_comb begin
        next_phase = phase;
        case (phase)
            PH_HOLD:   next_phase = PH_DECODE;
            PH_DECODE: next_phase = PH_RUN;
            PH_RUN:    next_phase = PH_RUN;
            default:   next_phase = PH_HOLD;
        endcase
        next_ready = (phase != PH_HOLD);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            phase       <= PH_HOLD;
            configReady <= 1'b0;
        end else begin
            phase       <= next_phase;
            configReady <= next_ready;
        end
    end

    // Decoded settings are flops; reset shows the documented defaults,
    // which keeps PCI and Ethernet off, with the host port on, while the pins still float.
    always_ff @(posedge clk) begin
        if (rst) begin
            endianMode          <= 1'b1;
            bootMode            <= BOOT_NONE;
            bootViaHost         <= 1'b0;
            bootViaPci          <= 1'b0;
            bootFromExtMem      <= 1'b0;
            bootReserved        <= 1'b0;
            extMemClockSelect   <= MCLK_INPUT;
            extMemClockReserved <= 1'b0;
            pciEnable           <= 1'b0;
            pciEepromLoad       <= 1'b0;
            pciSpeed33          <= 1'b0;
            hostPortEnable      <= 1'b1;
            hostPort32bit       <= 1'b0;
            hostDataUpperHiZ    <= 1'b1;
            ethernetEnable      <= 1'b0;
            selectReserved      <= 1'b0;
        end else begin
            endianMode          <= cap.endian;
            bootMode            <= cap.boot;
            bootViaHost         <= cap.boot == BOOT_HOST_PCI && !selPci;
            bootViaPci          <= cap.boot == BOOT_HOST_PCI && selPci;
            bootFromExtMem      <= cap.boot == BOOT_EXT_MEM;
            bootReserved        <= cap.boot == BOOT_RSVD;
            extMemClockSelect   <= cap.clkSel;
            extMemClockReserved <= cap.clkSel == MCLK_RSVD;
            pciEnable           <= selPci;
            pciEepromLoad       <= selPci && cap.eeprom;
            pciSpeed33          <= selPci && cap.speed;
            hostPortEnable      <= hostOn;
            hostPort32bit       <= hostOn && cap.width && !selEth;
            hostDataUpperHiZ    <= hostOn && !cap.width && !selEth;
            ethernetEnable      <= selEth;
            selectReserved      <= selRsvd;
        end
    end

    // Software enables, one generate entry per video port.
    genvar v;
    generate
        for (v = 0; v < 3; v++) begin : g_video
            assign videoPortEnable[v] =
                ifc.perSel[`RSCL_PS_VIDEO0 + v];
        end
    endgenerate
    assign i2cEnable         = ifc.perSel[`RSCL_PS_I2C];
    assign serialPort0Enable = ifc.perSel[`RSCL_PS_SERIAL0];
    assign serialPort1Enable = ifc.perSel[`RSCL_PS_SERIAL1];
    assign audioPortEnable   = ifc.perSel[`RSCL_PS_AUDIO];

    // Checks.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_release;
        $fell(rst);
    endsequence

    sequence s_ready_rise;
        !configReady [*2] ##1 configReady;
    endsequence

    a_capture_at_release:
        assert property (s_release |-> cap == $past(pinStraps))
        else $error("straps not taken from the last reset cycle");

    a_straps_hold:
        assert property (!$past(rst) |-> $stable(cap))
        else $error("captured straps changed outside reset");

    a_ready_timing:
        assert property (s_release |-> s_ready_rise)
        else $error("ready not raised two cycles after release");

    a_endian_decode:
        assert property (configReady |-> endianMode == cap.endian)
        else $error("endian mode differs from strap");

    a_boot_decode:
        assert property (configReady |->
            (bootViaPci == (cap.boot == BOOT_HOST_PCI && pciEnable))
            && (bootFromExtMem == (cap.boot == BOOT_EXT_MEM)))
        else $error("boot source decoded wrongly");

    a_clock_select:
        assert property (configReady |-> extMemClockSelect == cap.clkSel
            && extMemClockReserved == (cap.clkSel == MCLK_RSVD))
        else $error("memory clock select decoded wrongly");

    a_eeprom_load:
        assert property (configReady |->
            pciEepromLoad == (cap.eeprom && pciEnable))
        else $error("EEPROM load not tied to strap and PCI");

    a_pci_speed:
        assert property (configReady |->
            pciSpeed33 == (cap.speed && pciEnable))
        else $error("PCI speed not tied to strap and PCI");

    a_host_width:
        assert property (configReady && hostPortEnable |->
            hostPort32bit == (cap.width && !cap.macSel))
        else $error("host port width wrong");

    a_select_code:
        assert property (configReady |->
            pciEnable == ({cap.pciSel, cap.macSel} == 2'h2))
        else $error("PCI enable does not match select code");

    a_ethernet_host:
        assert property (configReady && ethernetEnable |->
            hostPortEnable == !cap.width && !hostPort32bit)
        else $error("host port wrong under Ethernet");

    a_pci_no_host:
        assert property (pciEnable |-> !hostPortEnable && !ethernetEnable)
        else $error("host port or Ethernet on with PCI");

    a_block_answer:
        assert property (cfgReq && ((cfgAddr & `RSCL_BLOCK_MASK)
            != `RSCL_BLOCK_BASE) |=> !cfgAck)
        else $error("answer to an address outside the block");

    a_select_write:
        assert property (cfgReq && cfgWe && cfgByteEn[0]
            && cfgAddr == `RSCL_PERSEL_ADDR
            |=> ifc.perSel == $past(cfgWdata[6:0]) && cfgAck)
        else $error("select word write not taken");

    a_select_read:
        assert property (cfgReq && !cfgWe && cfgAddr == `RSCL_PERSEL_ADDR
            |=> cfgRdata == {25'h0000000, $past(ifc.perSel)})
        else $error("select word read back wrong");

endmodule : rscl_strap_latch
`default_nettype wire

//--- rscl_regs.svh
// Register offsets, field positions and reset values of the strap latch.
`ifndef RSCL_REGS_SVH
`define RSCL_REGS_SVH

// The 4K configuration block and its registers.
`define RSCL_BLOCK_BASE   32'h01B3F000
`define RSCL_BLOCK_MASK   32'hFFFFF000
`define RSCL_PERSEL_ADDR  32'h01B3F000
`define RSCL_STATUS_ADDR  32'h01B3F004
`define RSCL_CHIPID_ADDR  32'h01B3F008

// Peripheral select fields.
`define RSCL_PERSEL_W     7
`define RSCL_PERSEL_RESET 7'h06
`define RSCL_PS_AUDIO     0
`define RSCL_PS_SERIAL0   1
`define RSCL_PS_SERIAL1   2
`define RSCL_PS_I2C       3
`define RSCL_PS_VIDEO0    4

// Device status fields, copies of the captured straps.
`define RSCL_ST_ENDIAN    0
`define RSCL_ST_BOOT      1
`define RSCL_ST_CLKSEL    3
`define RSCL_ST_EEPROM    5
`define RSCL_ST_SPEED     6
`define RSCL_ST_WIDTH     7
`define RSCL_ST_PCISEL    8
`define RSCL_ST_MACSEL    9
`define RSCL_ST_W         10

// Cycles from a block hit to its answer.
`define RSCL_ACK_CYCLES   1

`endif

//--- rscl_pkg.sv
// Types shared by the strap latch modules.
package rscl_pkg;

    // Boot source as coded on the boot mode straps.
    typedef enum logic [1:0] {
        BOOT_NONE     = 2'h0,
        BOOT_HOST_PCI = 2'h1,
        BOOT_RSVD     = 2'h2,
        BOOT_EXT_MEM  = 2'h3
    } rscl_boot_t;

    // External memory clock source.
    typedef enum logic [1:0] {
        MCLK_INPUT = 2'h0,
        MCLK_DIV4  = 2'h1,
        MCLK_DIV6  = 2'h2,
        MCLK_RSVD  = 2'h3
    } rscl_mclk_t;

    // Life of the configuration after reset, Gray coded.
    typedef enum logic [1:0] {
        PH_HOLD   = 2'h0,
        PH_DECODE = 2'h1,
        PH_RUN    = 2'h3
    } rscl_phase_t;

    // All strap levels as one word.
    typedef struct packed {
        logic       endian;
        rscl_boot_t boot;
        rscl_mclk_t clkSel;
        logic       eeprom;
        logic       speed;
        logic       width;
        logic       pciSel;
        logic       macSel;
    } rscl_straps_t;

endpackage : rscl_pkg

//--- rscl_cfg_if.sv
// Carrier between the strap capture, the register file and the core.
`timescale 1ns/100ps
`default_nettype none
interface rscl_cfg_if;
    import rscl_pkg::*;
    rscl_straps_t straps;
    logic [6:0]   perSel;
    logic         req;
    logic         we;
    logic [31:0]  addr;
    logic [3:0]   byteEn;
    logic [31:0]  wdata;
    logic [31:0]  rdata;
    logic         ack;

    modport cap  (output straps);
    modport regs (input straps, req, we, addr, byteEn, wdata,
                  output perSel, rdata, ack);
endinterface : rscl_cfg_if
`default_nettype wire

//--- rscl_strap_capture.sv
// Samples the strap pins while reset is held and freezes them afterwards.
`timescale 1ns/100ps
`default_nettype none
module rscl_strap_capture
    import rscl_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire rscl_straps_t pins,
    rscl_cfg_if.cap           cfg
);
    rscl_straps_t next_straps;

    // Follow the pins only while reset is high, so the last reset edge wins.
    always_comb begin
        next_straps = cfg.straps;
        if (rst) begin
            next_straps = pins;
        end
    end

    // The pins change role after reset; the copy must not follow them.
    always_ff @(posedge clk) begin
        cfg.straps <= next_straps;
    end
endmodule : rscl_strap_capture
`default_nettype wire

//--- rscl_cfg_regs.sv
// Configuration register file on the internal configuration bus.
`timescale 1ns/100ps
`default_nettype none
`include "rscl_regs.svh"
module rscl_cfg_regs
    import rscl_pkg::*;
#(
    parameter logic [31:0] CHIP_ID = 32'h00005A5A // Arbitrary value.
)(
    input  wire logic clk,
    input  wire logic rst,
    rscl_cfg_if.regs  cfg
);
    logic                       hit;
    logic [`RSCL_PERSEL_W-1:0]  next_perSel;
    logic [31:0]                next_rdata;
    logic                       next_ack;
    logic [`RSCL_ST_W-1:0]      status;

    assign hit = cfg.req
        && ((cfg.addr & `RSCL_BLOCK_MASK) == `RSCL_BLOCK_BASE);
    // Status word with the endian copy at bit 0 and the select straps on
    // top; the packed struct order is the reverse, so it is not used as is.
    assign status = {cfg.straps.macSel, cfg.straps.pciSel, cfg.straps.width,
                     cfg.straps.speed, cfg.straps.eeprom, cfg.straps.clkSel,
                     cfg.straps.boot, cfg.straps.endian};

    // Decode, write and read; other words of the block read as zero.
    always_comb begin
        next_perSel = cfg.perSel;
        next_rdata  = 32'h00000000;
        next_ack    = hit;
        if (hit && cfg.we && cfg.byteEn[0]
                && cfg.addr == `RSCL_PERSEL_ADDR) begin
            next_perSel = cfg.wdata[`RSCL_PERSEL_W-1:0];
        end
        if (hit && !cfg.we) begin
            case (cfg.addr)
                `RSCL_PERSEL_ADDR: next_rdata =
                    {25'h0000000, cfg.perSel};
                `RSCL_STATUS_ADDR: next_rdata = {22'h000000, status};
                `RSCL_CHIPID_ADDR: next_rdata = CHIP_ID;
                default:           next_rdata = 32'h00000000;
            endcase
        end
    end

    // Answer one cycle after the request; reset restores the select word.
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg.perSel <= `RSCL_PERSEL_RESET;
            cfg.rdata  <= 32'h00000000;
            cfg.ack    <= 1'b0;
        end else begin
            cfg.perSel <= next_perSel;
            cfg.rdata  <= next_rdata;
            cfg.ack    <= next_ack;
        end
    end
endmodule : rscl_cfg_regs
`default_nettype wire

//--- rscl_strap_board.sv
// Board model: strap pull resistors in reset, pin traffic afterwards.
`timescale 1ns/100ps
`default_nettype none
module rscl_strap_board
    import rscl_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire rscl_straps_t resistors,
    output rscl_straps_t      pins
);
    logic [9:0] traffic;

    // After reset the shared pins serve their own functions and change
    // every cycle, so a latch that kept sampling is caught at once.
    always_ff @(posedge clk) begin
        traffic <= rst ? 10'h000 : traffic + 10'h2AB;
    end

    // Only the resistors set the levels while reset is held.
    assign pins = rst ? resistors : rscl_straps_t'(~resistors ^ traffic);
endmodule : rscl_strap_board
`default_nettype wire

//--- test_reset_strap_config_latch.sv
// Self-checking bench for the strap latch and its register file.
`timescale 1ns/100ps
`default_nettype none
`include "rscl_regs.svh"
module test_reset_strap_config_latch
    import rscl_pkg::*;
;
    localparam logic [31:0] ID = 32'h0000C3C3; // Arbitrary value.
    logic clk, rst, cfgReq, cfgWe, cfgAck, configReady;
    logic [31:0] cfgAddr, cfgWdata, cfgRdata;
    logic [3:0] cfgByteEn;
    logic [1:0] bootMode, extMemClockSelect;
    logic [2:0] videoPortEnable;
    logic endianMode, bootViaHost, bootViaPci, bootFromExtMem, bootReserved;
    logic extMemClockReserved, pciEnable, pciEepromLoad, pciSpeed33;
    logic hostPortEnable, hostPort32bit, hostDataUpperHiZ, ethernetEnable;
    logic selectReserved, i2cEnable, serialPort0Enable, serialPort1Enable;
    logic audioPortEnable;
    logic [17:0] dec;
    logic [31:0] ena;
    rscl_straps_t board, pins, s;
    int num_errors, samples_checked;

    // Free-running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    rscl_strap_board i_board (.clk(clk), .rst(rst), .resistors(board),
        .pins(pins));

    rscl_strap_latch #(.CHIP_ID(ID)) i_dut (.clk(clk), .rst(rst),
        .endianStrap(pins.endian), .bootModeStrap(pins.boot),
        .extMemClockSelectStrap(pins.clkSel),
        .pciEepromAutoinitStrap(pins.eeprom), .pciSpeedStrap(pins.speed),
        .hostWidthStrap(pins.width), .pciSelectStrap(pins.pciSel),
        .ethernetSelectStrap(pins.macSel), .cfgReq(cfgReq), .cfgWe(cfgWe),
        .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWdata(cfgWdata),
        .cfgRdata(cfgRdata), .cfgAck(cfgAck), .endianMode(endianMode),
        .bootMode(bootMode), .bootViaHost(bootViaHost),
        .bootViaPci(bootViaPci), .bootFromExtMem(bootFromExtMem),
        .bootReserved(bootReserved), .extMemClockSelect(extMemClockSelect),
        .extMemClockReserved(extMemClockReserved), .pciEnable(pciEnable),
        .pciEepromLoad(pciEepromLoad), .pciSpeed33(pciSpeed33),
        .hostPortEnable(hostPortEnable), .hostPort32bit(hostPort32bit),
        .hostDataUpperHiZ(hostDataUpperHiZ), .ethernetEnable(ethernetEnable),
        .selectReserved(selectReserved), .configReady(configReady),
        .videoPortEnable(videoPortEnable), .i2cEnable(i2cEnable),
        .serialPort0Enable(serialPort0Enable),
        .serialPort1Enable(serialPort1Enable),
        .audioPortEnable(audioPortEnable));

    // Decoded settings and select enables gathered for one compare each.
    assign dec = {endianMode, bootMode, bootViaHost, bootViaPci,
        bootFromExtMem, bootReserved, extMemClockSelect, extMemClockReserved,
        pciEnable, pciEepromLoad, pciSpeed33, hostPortEnable, hostPort32bit,
        hostDataUpperHiZ, ethernetEnable, selectReserved};
    assign ena = {25'h0, videoPortEnable, i2cEnable, serialPort1Enable,
        serialPort0Enable, audioPortEnable};

    // Expected decode; reserved select codes switch every port off.
    function automatic logic [31:0] expDec(input rscl_straps_t t);
        logic [1:0] sel;
        logic pci, eth, host;
        sel = {t.pciSel, t.macSel};
        pci = sel == 2'h2;
        eth = sel == 2'h1;
        host = sel == 2'h0 || (eth && !t.width);
        return {14'h0, t.endian, t.boot, t.boot == BOOT_HOST_PCI && !pci,
            t.boot == BOOT_HOST_PCI && pci, t.boot == BOOT_EXT_MEM,
            t.boot == BOOT_RSVD, t.clkSel, t.clkSel == MCLK_RSVD, pci,
            pci && t.eeprom, pci && t.speed, host, host && t.width,
            host && !t.width && !eth, eth, sel == 2'h3};
    endfunction : expDec

    // Strap set number i; the table reaches every code of every field.
    function automatic rscl_straps_t mk(input logic [3:0] i);
        rscl_straps_t t;
        t.endian = ~i[0];
        t.boot = rscl_boot_t'((i[3] && i[2]) ? 2'h2 : i[1:0]);
        t.clkSel = rscl_mclk_t'(i[2:1]);
        t.eeprom = i[1];
        t.speed = i[0];
        t.width = i[0] ^ i[2];
        t.pciSel = i[3];
        t.macSel = i[2];
        return t;
    endfunction : mk

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One configuration bus access; the request stands for one cycle.
    task automatic bus(input logic we, input logic [31:0] a,
        input logic [3:0] be, input logic [31:0] wd, output logic ack,
        output logic [31:0] rd);
        int n;
        @(posedge clk);
        #1;
        cfgReq = 1'b1;
        cfgWe = we;
        cfgAddr = a;
        cfgByteEn = be;
        cfgWdata = wd;
        ack = 1'b0;
        rd = 32'h0;
        n = 0;
        while (!ack && n < 3) begin
            @(posedge clk);
            #1;
            cfgReq = 1'b0;
            ack = cfgAck === 1'b1;
            rd = cfgRdata;
            n++;
        end
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [3:0] be,
        input logic [31:0] d);
        logic k;
        logic [31:0] r;
        bus(1'b1, a, be, d, k, r);
        chk({31'h0, k}, 32'h1);
    endtask : wr

    task automatic rdChk(input logic [31:0] a, input logic [31:0] exp);
        logic k;
        logic [31:0] r;
        bus(1'b0, a, 4'hF, 32'h0, k, r);
        chk({31'h0, k}, 32'h1);
        chk(r, exp);
    endtask : rdChk

    // Other levels first, so only the last edge in reset holds the set.
    task automatic doReset(input int n, input rscl_straps_t t);
        board = ~t;
        rst = 1'b1;
        repeat (n - 1) @(posedge clk);
        #1 board = t;
        @(posedge clk);
        #1 rst = 1'b0;
        @(posedge clk);
        #1 chk({31'h0, configReady}, 32'h0);
        @(posedge clk);
        #1 chk({31'h0, configReady}, 32'h1);
    endtask : doReset

    task automatic test_done;
        $display("errors=%0d checks=%0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done

    // A hang is cut short well beyond the expected run length.
    initial begin
        repeat (4000) @(posedge clk);
        num_errors++;
        test_done;
    end

    initial begin
        logic k;
        logic [31:0] r;
        rst = 1'b1;
        board = mk(4'h0);
        cfgReq = 1'b0;
        cfgWe = 1'b0;
        cfgAddr = 32'h0;
        cfgByteEn = 4'h0;
        cfgWdata = 32'h0;
        num_errors = 0;
        samples_checked = 0;
        doReset(8, mk(4'h0));
        // Software control of the select word, reserved bits read zero.
        rdChk(`RSCL_PERSEL_ADDR, 32'h6);
        chk(ena, 32'h6);
        wr(`RSCL_PERSEL_ADDR, 4'hF, 32'hFFFFFFFF);
        rdChk(`RSCL_PERSEL_ADDR, 32'h7F);
        chk(ena, 32'h7F);
        wr(`RSCL_PERSEL_ADDR, 4'hE, 32'h0);
        rdChk(`RSCL_PERSEL_ADDR, 32'h7F);
        wr(`RSCL_PERSEL_ADDR, 4'h1, 32'h29);
        chk(ena, 32'h29);
        // Other registers, an unmapped word and addresses off the block.
        rdChk(`RSCL_CHIPID_ADDR, ID);
        wr(`RSCL_STATUS_ADDR, 4'hF, 32'hFFFFFFFF);
        rdChk(`RSCL_STATUS_ADDR, 32'h1);
        rdChk(`RSCL_BLOCK_BASE + 32'hFFC, 32'h0);
        bus(1'b0, `RSCL_BLOCK_BASE + 32'h1000, 4'hF, 32'h0, k, r);
        chk({31'h0, k}, 32'h0);
        bus(1'b1, `RSCL_BLOCK_BASE - 32'h4, 4'hF, 32'h0, k, r);
        chk({31'h0, k}, 32'h0);
        // Every strap set, held while the shared pins toggle afterwards.
        for (int i = 0; i < 16; i++) begin
            s = mk(i[3:0]);
            doReset(3, s);
            chk({14'h0, dec}, expDec(s));
            chk({14'h0, dec}, expDec(s));
            repeat (20) @(posedge clk);
            chk({14'h0, dec}, expDec(s));
            rdChk(`RSCL_STATUS_ADDR, {22'h0, s.macSel, s.pciSel, s.width,
                s.speed, s.eeprom, s.clkSel, s.boot, s.endian});
            rdChk(`RSCL_PERSEL_ADDR, 32'h6);
        end
        test_done;
    end
endmodule : test_reset_strap_config_latch
`default_nettype wire
